// [hw/inband_flow_pkg.sv]
// Constants shared by the in-band flow control block and its receive matcher.
package inband_flow_pkg;
  // Register word addresses on the plain register port.
  localparam logic [2:0] ADDR_RESUME_A = 3'h0;
  localparam logic [2:0] ADDR_RESUME_B = 3'h1;
  localparam logic [2:0] ADDR_PAUSE_A = 3'h2;
  localparam logic [2:0] ADDR_PAUSE_B = 3'h3;
  localparam logic [2:0] ADDR_FLOW_MODE = 3'h4;
  localparam logic [2:0] ADDR_FIFO_SETUP = 3'h5;
  localparam logic [2:0] ADDR_THRESHOLD = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;

  // Flow mode register fields.
  localparam int MODE_RX_LSB = 0;
  localparam int MODE_TX_LSB = 2;
  localparam int MODE_SRC_LSB = 4;
  localparam int MODE_FIFO_EN_BIT = 6;

  // Threshold register fields, each in steps of four entries.
  localparam int THR_HALT_LSB = 0;
  localparam int THR_RESUME_LSB = 4;
  localparam int THR_STEP_SHIFT = 2;

  // Status register bits.
  localparam int STAT_HALTED_BIT = 0;
  localparam int STAT_PAUSE_SENT_BIT = 1;
  localparam int STAT_CFG_ERR_BIT = 2;
  localparam int STAT_SEQ_WAIT_BIT = 3;
  localparam int STAT_SPEC_BUSY_BIT = 4;

  // Reset values.
  localparam logic [7:0] RST_CHAR = 8'h00;
  localparam logic [7:0] RST_FLOW_MODE = 8'h00;
  localparam logic [7:0] RST_FIFO_SETUP = 8'h00;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;

  // Two-bit pairing field codes.
  localparam logic [1:0] PAIR_NONE = 2'h0;
  localparam logic [1:0] PAIR_B = 2'h1;
  localparam logic [1:0] PAIR_A = 2'h2;
  localparam logic [1:0] PAIR_BOTH = 2'h3;

  // Threshold source codes.
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_SEPARATE = 2'h1;
  localparam logic [1:0] SRC_PRESET = 2'h2;

  // Preset halt levels and the next lower level used for resume.
  localparam logic [6:0] PRESET_HALT_0 = 7'h08;
  localparam logic [6:0] PRESET_HALT_1 = 7'h10;
  localparam logic [6:0] PRESET_HALT_2 = 7'h20;
  localparam logic [6:0] PRESET_HALT_3 = 7'h38;
  localparam logic [6:0] PRESET_RESUME_0 = 7'h00;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_GOT_PAUSE_A = 2'b01,
    SEQ_GOT_RESUME_A = 2'b10
  } seq_state_t;
endpackage

// [hw/inband_rx_match.sv]
// Receive-side comparison of incoming characters against the special characters.
`timescale 1ns/1ps
module inband_rx_match #(
  parameter int CHAR_W = 8
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Configuration
  input wire logic [3:0] char_pairing_select_in,
  input wire logic [CHAR_W-1:0] resume_char_a_in,
  input wire logic [CHAR_W-1:0] resume_char_b_in,
  input wire logic [CHAR_W-1:0] pause_char_a_in,
  input wire logic [CHAR_W-1:0] pause_char_b_in,
  // Incoming characters
  input wire logic [CHAR_W-1:0] rx_char_in,
  input wire logic rx_char_valid_in,
  // Forwarded characters and events
  output logic [CHAR_W-1:0] pass_data_out,
  output logic pass_valid_out,
  output logic pause_evt_out,
  output logic resume_evt_out,
  output logic seq_wait_out
);
  logic [1:0] rx_field;
  logic [1:0] tx_field;
  logic either_mode;
  logic seq_mode;
  logic is_ra, is_rb, is_pa, is_pb;
  logic hit_pause, hit_resume, drop;
  inband_flow_pkg::seq_state_t seq_r;
  inband_flow_pkg::seq_state_t seq_nxt;

  assign rx_field = char_pairing_select_in[inband_flow_pkg::MODE_RX_LSB +: 2];
  assign tx_field = char_pairing_select_in[inband_flow_pkg::MODE_TX_LSB +: 2];
  assign either_mode = (rx_field == inband_flow_pkg::PAIR_BOTH) &&
                       ((tx_field == inband_flow_pkg::PAIR_A) ||
                        (tx_field == inband_flow_pkg::PAIR_B));
  assign seq_mode = (rx_field == inband_flow_pkg::PAIR_BOTH) && !either_mode;
  assign is_ra = (rx_char_in == resume_char_a_in);
  assign is_rb = (rx_char_in == resume_char_b_in);
  assign is_pa = (rx_char_in == pause_char_a_in);
  assign is_pb = (rx_char_in == pause_char_b_in);

  // Every character is compared while the receive field is non-zero.
  always_comb begin
    hit_pause = 1'b0;
    hit_resume = 1'b0;
    drop = 1'b0;
    seq_nxt = inband_flow_pkg::SEQ_IDLE;
    case (rx_field)
      inband_flow_pkg::PAIR_A: begin
        hit_pause = is_pa;
        hit_resume = is_ra;
        drop = is_pa | is_ra;
      end
      inband_flow_pkg::PAIR_B: begin
        hit_pause = is_pb;
        hit_resume = is_rb;
        drop = is_pb | is_rb;
      end
      inband_flow_pkg::PAIR_BOTH: begin
        drop = is_pa | is_pb | is_ra | is_rb;
        if (either_mode) begin
          hit_pause = is_pa | is_pb;
          hit_resume = is_ra | is_rb;
        end else begin
          // The second character must directly follow the first one.
          hit_pause = (seq_r == inband_flow_pkg::SEQ_GOT_PAUSE_A) && is_pb;
          hit_resume = (seq_r == inband_flow_pkg::SEQ_GOT_RESUME_A) && is_rb;
          if (is_pa) begin
            seq_nxt = inband_flow_pkg::SEQ_GOT_PAUSE_A;
          end else if (is_ra) begin
            seq_nxt = inband_flow_pkg::SEQ_GOT_RESUME_A;
          end
        end
      end
      default: begin
        drop = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !seq_mode) begin
      seq_r <= inband_flow_pkg::SEQ_IDLE;
    end else if (rx_char_valid_in) begin
      seq_r <= seq_nxt;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pass_valid_out <= 1'b0;
      pass_data_out <= '0;
      pause_evt_out <= 1'b0;
      resume_evt_out <= 1'b0;
    end else begin
      pass_valid_out <= rx_char_valid_in && !drop;
      pass_data_out <= rx_char_in;
      pause_evt_out <= rx_char_valid_in && hit_pause;
      resume_evt_out <= rx_char_valid_in && hit_resume;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      seq_wait_out <= 1'b0;
    end else begin
      seq_wait_out <= seq_mode && (seq_nxt != inband_flow_pkg::SEQ_IDLE) && rx_char_valid_in ||
                      seq_mode && !rx_char_valid_in && (seq_r != inband_flow_pkg::SEQ_IDLE);
    end
  end
endmodule

// [hw/uart_auto_xon_xoff_flow.sv]
// In-band pause/resume flow control for a serial port: receive matching and sending.
//
// Functional notes
// - With receive compare enabled, every incoming character is compared to pause characters.
// - Characters matching the compared pair's pause or resume characters never reach the receive FIFO.
// - After a pause, the current character finishes; no new data until resume.
// - Send resume below resume level, pause above halt level, when sending is enabled.
// - Four programmable eight-bit characters: two resume, two pause.
// - Separate thresholds range zero to sixty entries in steps of four.
// - Transmit field: 10 first pair, 01 second pair, 11 both, 00 off.
// - Receive field: 10 first pair, 01 second pair, 00 off.
// - Transmit 10 or 01 with receive 11: either character of a kind matches.
// - Transmit 11 or 00 with receive 11: two-character sequences are required.
// - Transmit sending and receive comparing are enabled independently.
// - With no threshold source, occupancy never triggers special characters.
// - Preset source: chosen preset is halt level, next lower preset is resume.
// - Threshold sending only while FIFOs enabled and a transmit pairing is selected.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module uart_auto_xon_xoff_flow #(
  parameter int CHAR_W = 8,
  parameter int LEVEL_W = 7
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Receiver side
  input wire logic [CHAR_W-1:0] rx_char_in,
  input wire logic rx_char_valid_in,
  input wire logic [LEVEL_W-1:0] rx_fifo_level_in,
  output logic [CHAR_W-1:0] rx_fifo_data_out,
  output logic rx_fifo_wr_out,
  // Transmit FIFO side
  input wire logic [CHAR_W-1:0] tx_data_in,
  input wire logic tx_data_valid_in,
  output logic tx_data_ready_out,
  // Transmitter side
  output logic [CHAR_W-1:0] tx_char_out,
  output logic tx_char_valid_out,
  input wire logic tx_char_ready_in,
  // Flow state
  output logic tx_halted_out
);
  if (CHAR_W != 8) begin : g_char_check
    $error("CHAR_W must be 8");
  end
  if (LEVEL_W < 7) begin : g_level_check
    $error("LEVEL_W must hold a level of 64");
  end

  logic [CHAR_W-1:0] resume_char_a_r;
  logic [CHAR_W-1:0] resume_char_b_r;
  logic [CHAR_W-1:0] pause_char_a_r;
  logic [CHAR_W-1:0] pause_char_b_r;
  logic [7:0] inband_flow_mode_r;
  logic [7:0] fifo_setup_reg_r;
  logic [7:0] threshold_pair_reg_r;
  logic [3:0] char_pairing_select;
  logic [1:0] tx_field;
  logic [1:0] threshold_source_select;
  logic fifo_en;
  logic [1:0] preset_rx_threshold;
  logic [6:0] halt_level;
  logic [6:0] resume_level;
  logic [6:0] level;
  logic cfg_err;
  logic thr_active;
  logic pause_sent_r;
  logic want_pause;
  logic want_resume;
  logic [1:0] spec_left_r;
  logic spec_pause_r;
  logic spec_use_b_r;
  logic spec_start;
  logic slot_free;
  logic load_spec;
  logic load_data;
  logic valid_nxt;
  logic halted_nxt;
  logic [1:0] spec_left_nxt;
  logic pause_evt;
  logic resume_evt;
  logic seq_wait;
  logic [7:0] status;

  // Picks the special character for a kind and a pair.
  function automatic logic [CHAR_W-1:0] spec_char(input logic is_pause, input logic use_b,
      input logic [CHAR_W-1:0] ra, input logic [CHAR_W-1:0] rb,
      input logic [CHAR_W-1:0] pa, input logic [CHAR_W-1:0] pb);
    if (is_pause) begin
      spec_char = use_b ? pb : pa;
    end else begin
      spec_char = use_b ? rb : ra;
    end
  endfunction

  // Scales a four-bit threshold field to entries.
  function automatic logic [6:0] thr_entries(input logic [3:0] field);
    thr_entries = {1'b0, field, 2'b00};
  endfunction

  assign char_pairing_select = inband_flow_mode_r[inband_flow_pkg::MODE_RX_LSB +: 4];
  assign tx_field = inband_flow_mode_r[inband_flow_pkg::MODE_TX_LSB +: 2];
  assign threshold_source_select = inband_flow_mode_r[inband_flow_pkg::MODE_SRC_LSB +: 2];
  assign fifo_en = inband_flow_mode_r[inband_flow_pkg::MODE_FIFO_EN_BIT];
  assign preset_rx_threshold = fifo_setup_reg_r[1:0];
  assign level = rx_fifo_level_in[6:0];

  // Level pair chosen by the threshold source.
  always_comb begin
    halt_level = thr_entries(threshold_pair_reg_r[inband_flow_pkg::THR_HALT_LSB +: 4]);
    resume_level = thr_entries(threshold_pair_reg_r[inband_flow_pkg::THR_RESUME_LSB +: 4]);
    if (threshold_source_select == inband_flow_pkg::SRC_PRESET) begin
      case (preset_rx_threshold)
        2'h0: begin
          halt_level = inband_flow_pkg::PRESET_HALT_0;
          resume_level = inband_flow_pkg::PRESET_RESUME_0;
        end
        2'h1: begin
          halt_level = inband_flow_pkg::PRESET_HALT_1;
          resume_level = inband_flow_pkg::PRESET_HALT_0;
        end
        2'h2: begin
          halt_level = inband_flow_pkg::PRESET_HALT_2;
          resume_level = inband_flow_pkg::PRESET_HALT_1;
        end
        default: begin
          halt_level = inband_flow_pkg::PRESET_HALT_3;
          resume_level = inband_flow_pkg::PRESET_HALT_2;
        end
      endcase
    end
  end

  // With separate thresholds, a halt level not above the resume level is flagged and never drives sending.
  assign cfg_err = (threshold_source_select == inband_flow_pkg::SRC_SEPARATE) &&
                   (halt_level <= resume_level);
  assign thr_active = fifo_en && (tx_field != inband_flow_pkg::PAIR_NONE) && !cfg_err &&
                      ((threshold_source_select == inband_flow_pkg::SRC_SEPARATE) ||
                       (threshold_source_select == inband_flow_pkg::SRC_PRESET));
  assign want_pause = thr_active && !pause_sent_r && (level > halt_level);
  assign want_resume = thr_active && pause_sent_r && (level < resume_level);
  assign spec_start = (spec_left_r == 2'd0) && (want_pause || want_resume);

  // Register writes.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      resume_char_a_r <= inband_flow_pkg::RST_CHAR;
      resume_char_b_r <= inband_flow_pkg::RST_CHAR;
      pause_char_a_r <= inband_flow_pkg::RST_CHAR;
      pause_char_b_r <= inband_flow_pkg::RST_CHAR;
      inband_flow_mode_r <= inband_flow_pkg::RST_FLOW_MODE;
      fifo_setup_reg_r <= inband_flow_pkg::RST_FIFO_SETUP;
      threshold_pair_reg_r <= inband_flow_pkg::RST_THRESHOLD;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        inband_flow_pkg::ADDR_RESUME_A: resume_char_a_r <= reg_wdata_in;
        inband_flow_pkg::ADDR_RESUME_B: resume_char_b_r <= reg_wdata_in;
        inband_flow_pkg::ADDR_PAUSE_A: pause_char_a_r <= reg_wdata_in;
        inband_flow_pkg::ADDR_PAUSE_B: pause_char_b_r <= reg_wdata_in;
        inband_flow_pkg::ADDR_FLOW_MODE: inband_flow_mode_r <= {1'b0, reg_wdata_in[6:0]};
        inband_flow_pkg::ADDR_FIFO_SETUP: fifo_setup_reg_r <= {6'h00, reg_wdata_in[1:0]};
        inband_flow_pkg::ADDR_THRESHOLD: threshold_pair_reg_r <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    status = 8'h00;
    status[inband_flow_pkg::STAT_HALTED_BIT] = tx_halted_out;
    status[inband_flow_pkg::STAT_PAUSE_SENT_BIT] = pause_sent_r;
    status[inband_flow_pkg::STAT_CFG_ERR_BIT] = cfg_err;
    status[inband_flow_pkg::STAT_SEQ_WAIT_BIT] = seq_wait;
    status[inband_flow_pkg::STAT_SPEC_BUSY_BIT] = (spec_left_r != 2'd0);
  end

  // Register reads answer in the following cycle only.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        inband_flow_pkg::ADDR_RESUME_A: reg_rdata_out <= resume_char_a_r;
        inband_flow_pkg::ADDR_RESUME_B: reg_rdata_out <= resume_char_b_r;
        inband_flow_pkg::ADDR_PAUSE_A: reg_rdata_out <= pause_char_a_r;
        inband_flow_pkg::ADDR_PAUSE_B: reg_rdata_out <= pause_char_b_r;
        inband_flow_pkg::ADDR_FLOW_MODE: reg_rdata_out <= inband_flow_mode_r;
        inband_flow_pkg::ADDR_FIFO_SETUP: reg_rdata_out <= fifo_setup_reg_r;
        inband_flow_pkg::ADDR_THRESHOLD: reg_rdata_out <= threshold_pair_reg_r;
        default: reg_rdata_out <= status;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  inband_rx_match #(
    .CHAR_W(CHAR_W)
  ) u_rx_match (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .char_pairing_select_in(char_pairing_select),
    .resume_char_a_in(resume_char_a_r),
    .resume_char_b_in(resume_char_b_r),
    .pause_char_a_in(pause_char_a_r),
    .pause_char_b_in(pause_char_b_r),
    .rx_char_in(rx_char_in),
    .rx_char_valid_in(rx_char_valid_in),
    .pass_data_out(rx_fifo_data_out),
    .pass_valid_out(rx_fifo_wr_out),
    .pause_evt_out(pause_evt),
    .resume_evt_out(resume_evt),
    .seq_wait_out(seq_wait)
  );

  // Halting follows receive comparison whatever the transmit pairing; turning comparison off releases a halt.
  always_comb begin
    halted_nxt = tx_halted_out;
    if (pause_evt) begin
      halted_nxt = 1'b1;
    end else if (char_pairing_select[1:0] == inband_flow_pkg::PAIR_NONE) begin
      halted_nxt = 1'b0;
    end else if (resume_evt) begin
      halted_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tx_halted_out <= 1'b0;
    end else begin
      tx_halted_out <= halted_nxt;
    end
  end

  // Hysteresis state: a crossing is only recorded when its sequence is queued.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !thr_active) begin
      pause_sent_r <= 1'b0;
    end else if (spec_start) begin
      pause_sent_r <= want_pause;
    end
  end

  // Special characters win the output slot over queued data.
  assign slot_free = !tx_char_valid_out || tx_char_ready_in;
  assign load_spec = slot_free && (spec_left_r != 2'd0);
  assign load_data = slot_free && (spec_left_r == 2'd0) && tx_data_ready_out &&
                     tx_data_valid_in;
  assign valid_nxt = load_spec || load_data || (tx_char_valid_out && !tx_char_ready_in);

  always_comb begin
    spec_left_nxt = spec_left_r;
    if (spec_start) begin
      spec_left_nxt = (tx_field == inband_flow_pkg::PAIR_BOTH) ? 2'd2 : 2'd1;
    end else if (load_spec) begin
      spec_left_nxt = spec_left_r - 2'd1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      spec_left_r <= 2'd0;
      spec_pause_r <= 1'b0;
      spec_use_b_r <= 1'b0;
    end else begin
      spec_left_r <= spec_left_nxt;
      if (spec_start) begin
        spec_pause_r <= want_pause;
        spec_use_b_r <= (tx_field == inband_flow_pkg::PAIR_B);
      end else if (load_spec) begin
        spec_use_b_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tx_char_valid_out <= 1'b0;
      tx_char_out <= '0;
    end else begin
      tx_char_valid_out <= valid_nxt;
      if (load_spec) begin
        tx_char_out <= spec_char(spec_pause_r, spec_use_b_r, resume_char_a_r,
                                 resume_char_b_r, pause_char_a_r, pause_char_b_r);
      end else if (load_data) begin
        tx_char_out <= tx_data_in;
      end
    end
  end

  // Data is offered only with an empty slot, no special pending and no halt.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tx_data_ready_out <= 1'b0;
    end else begin
      tx_data_ready_out <= !valid_nxt && (spec_left_nxt == 2'd0) && !halted_nxt;
    end
  end
endmodule

// [testbench/remote_tx_sink.sv]
// Far-side transmitter model that takes characters only at character boundaries.
`timescale 1ns/1ps
module remote_tx_sink (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Character hand-off
  input wire logic [7:0] char_in,
  input wire logic valid_in,
  output logic ready_out,
  // Control and capture
  input wire logic slow_in,
  output logic [7:0] got_char_out,
  output logic got_out
);
  logic [1:0] div_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  // A slow line reaches a boundary every fourth cycle, so the sender must hold its character.
  assign ready_out = !slow_in || (div_r == 2'h3);

  always_ff @(posedge clk_in) begin
    got_out <= !rst_in && valid_in && ready_out;
    got_char_out <= char_in;
  end
endmodule

// [testbench/tb_uart_auto_xon_xoff_flow.sv]
// Self-checking bench for the in-band flow control block.
`timescale 1ns/1ps
module tb_uart_auto_xon_xoff_flow;
  logic sys_clk_in, sys_rst_in, reg_wr_in, reg_rd_in, rx_char_valid_in, rx_fifo_wr_out;
  logic tx_data_valid_in, tx_data_ready_out, tx_char_valid_out, tx_char_ready_in;
  logic tx_halted_out, slow, got;
  logic [2:0] reg_addr_in;
  logic [6:0] rx_fifo_level_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, rx_char_in, rx_fifo_data_out, tx_data_in;
  logic [7:0] tx_char_out, got_char, ra, rb, pa, pb, dx, d;
  logic [7:0] exp_rx[$], got_rx[$], exp_tx[$], got_tx[$];
  logic [7:0] modes[5] = '{8'h58, 8'h54, 8'h5C, 8'h58, 8'h68};
  logic [7:0] thrs[5] = '{8'h12, 8'h12, 8'h12, 8'hEF, 8'h00};
  int his[5] = '{8, 8, 8, 60, 16};
  int los[5] = '{4, 4, 4, 56, 8};
  int n_mismatch, checks_done;

  uart_auto_xon_xoff_flow uut (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .rx_char_in(rx_char_in),
    .rx_char_valid_in(rx_char_valid_in), .rx_fifo_level_in(rx_fifo_level_in),
    .rx_fifo_data_out(rx_fifo_data_out), .rx_fifo_wr_out(rx_fifo_wr_out),
    .tx_data_in(tx_data_in), .tx_data_valid_in(tx_data_valid_in),
    .tx_data_ready_out(tx_data_ready_out), .tx_char_out(tx_char_out),
    .tx_char_valid_out(tx_char_valid_out), .tx_char_ready_in(tx_char_ready_in),
    .tx_halted_out(tx_halted_out));
  remote_tx_sink far (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .char_in(tx_char_out),
    .valid_in(tx_char_valid_out), .ready_out(tx_char_ready_in), .slow_in(slow),
    .got_char_out(got_char), .got_out(got));

  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    if (rx_fifo_wr_out === 1'b1) got_rx.push_back(rx_fifo_data_out);
    if (got === 1'b1) got_tx.push_back(got_char);
  end

  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cmp_q(ref logic [7:0] e[$], ref logic [7:0] g[$]);
    check("char count", 8'(g.size()), 8'(e.size()));
    for (int i = 0; i < e.size() && i < g.size(); i++) check("char", g[i], e[i]);
    e.delete();
    g.delete();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    cyc(1);
    reg_wr_in <= 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    cyc(1);
    reg_rd_in <= 1'b0;
    cyc(1);
    v = reg_rdata_out;
  endtask

  task automatic rx(input logic [7:0] c);
    rx_char_in <= c;
    rx_char_valid_in <= 1'b1;
    cyc(1);
    rx_char_valid_in <= 1'b0;
    cyc(1);
  endtask

  task automatic halted(input logic v);
    cyc(2);
    check("halted", tx_halted_out, v);
  endtask

  task automatic put_data(input logic [7:0] v);
    int k;
    tx_data_in <= v;
    tx_data_valid_in <= 1'b1;
    for (k = 0; k < 40; k++) begin
      cyc(1);
      if (tx_data_ready_out === 1'b1) break;
    end
    tx_data_valid_in <= 1'b0;
    cyc(1);
    if (k == 40) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task automatic wait_tx(input int n);
    int k;
    for (k = 0; k < 300 && got_tx.size() < n; k++) cyc(1);
    if (got_tx.size() < n) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  initial begin
    sys_rst_in = 1'b1;
    reg_addr_in = 3'h0;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    rx_char_in = 8'h00;
    rx_char_valid_in = 1'b0;
    rx_fifo_level_in = 7'h00;
    tx_data_in = 8'h00;
    tx_data_valid_in = 1'b0;
    slow = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    ra = 8'($urandom(32'h35293605) % 200);
    rb = ra + 8'h01;
    pa = ra + 8'h02;
    pb = ra + 8'h03;
    dx = ra + 8'h04;
    cyc(3);
    sys_rst_in <= 1'b0;
    cyc(1);
    for (int i = 0; i < 4; i++) wr(3'(i), ra + 8'(i));
    for (int i = 0; i < 4; i++) begin
      rd(3'(i), d);
      check("special char", d, ra + 8'(i));
    end
    wr(inband_flow_pkg::ADDR_STATUS, 8'hFF);
    rd(inband_flow_pkg::ADDR_STATUS, d);
    check("status", d, 8'h00);
    // Single-pair compare: the other pair's pause passes through as data.
    for (int i = 0; i < 2; i++) begin
      wr(3'h4, i ? 8'h01 : 8'h02);
      rx(dx);
      rx(i ? pb : pa);
      halted(1'b1);
      check("ready", tx_data_ready_out, 1'b0);
      rd(inband_flow_pkg::ADDR_STATUS, d);
      check("status halt", d[inband_flow_pkg::STAT_HALTED_BIT], 1'b1);
      rx(i ? pa : pb);
      rx(i ? rb : ra);
      halted(1'b0);
      put_data(dx);
      exp_rx.push_back(dx);
      exp_rx.push_back(i ? pa : pb);
      exp_tx.push_back(dx);
    end
    wait_tx(2);
    cmp_q(exp_tx, got_tx);
    for (int i = 0; i < 2; i++) begin
      wr(3'h4, i ? 8'h07 : 8'h0B);
      rx(i ? pa : pb);
      halted(1'b1);
      rx(i ? rb : ra);
      halted(1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      wr(3'h4, i ? 8'h03 : 8'h0F);
      rx(pa);
      rx(dx);
      exp_rx.push_back(dx);
      halted(1'b0);
      rx(pa);
      rx(pb);
      halted(1'b1);
      rx(ra);
      rx(rb);
      halted(1'b0);
    end
    cyc(2);
    cmp_q(exp_rx, got_rx);
    wr(3'h4, 8'h00);
    wr(inband_flow_pkg::ADDR_FIFO_SETUP, 8'h01);
    slow <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(inband_flow_pkg::ADDR_THRESHOLD, thrs[i]);
      wr(3'h4, modes[i]);
      rx_fifo_level_in <= 7'(his[i]);
      cyc(10);
      rx_fifo_level_in <= 7'(his[i] + 1);
      if (modes[i][3]) exp_tx.push_back(pa);
      if (modes[i][2]) exp_tx.push_back(pb);
      wait_tx(exp_tx.size());
      cyc(16);
      rx_fifo_level_in <= 7'(los[i]);
      cyc(10);
      rx_fifo_level_in <= 7'(los[i] - 1);
      if (modes[i][3]) exp_tx.push_back(ra);
      if (modes[i][2]) exp_tx.push_back(rb);
      wait_tx(exp_tx.size());
      cyc(16);
      cmp_q(exp_tx, got_tx);
      rx_fifo_level_in <= 7'h00;
    end
    // No source, FIFOs off, no transmit pairing and a halt level equal to the resume level all stay silent.
    for (int i = 0; i < 4; i++) begin
      wr(inband_flow_pkg::ADDR_THRESHOLD, i == 3 ? 8'h22 : 8'h12);
      wr(3'h4, i == 0 ? 8'h48 : (i == 1 ? 8'h18 : (i == 2 ? 8'h50 : 8'h58)));
      rx_fifo_level_in <= 7'h20;
      cyc(30);
      rx_fifo_level_in <= 7'h00;
      cyc(30);
      cmp_q(exp_tx, got_tx);
    end
    rd(inband_flow_pkg::ADDR_STATUS, d);
    check("config error", d[inband_flow_pkg::STAT_CFG_ERR_BIT], 1'b1);
    wr(3'h4, 8'h00);
    report_and_stop();
  end
endmodule

bind uart_auto_xon_xoff_flow uart_flow_asserts #(.CHAR_W(CHAR_W)) chk (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx_char_in(rx_char_in),
  .rx_char_valid_in(rx_char_valid_in), .rx_fifo_data_out(rx_fifo_data_out),
  .rx_fifo_wr_out(rx_fifo_wr_out), .tx_data_in(tx_data_in),
  .tx_data_valid_in(tx_data_valid_in), .tx_data_ready_out(tx_data_ready_out),
  .tx_char_out(tx_char_out), .tx_char_valid_out(tx_char_valid_out),
  .tx_char_ready_in(tx_char_ready_in), .tx_halted_out(tx_halted_out));

// [testbench/uart_flow_asserts.sv]
// Concurrent checks on the ports of the in-band flow control block.
`timescale 1ns/1ps
module uart_flow_asserts #(
  parameter int CHAR_W = 8
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Receive path
  input wire logic [CHAR_W-1:0] rx_char_in,
  input wire logic rx_char_valid_in,
  input wire logic [CHAR_W-1:0] rx_fifo_data_out,
  input wire logic rx_fifo_wr_out,
  // Transmit path
  input wire logic [CHAR_W-1:0] tx_data_in,
  input wire logic tx_data_valid_in,
  input wire logic tx_data_ready_out,
  input wire logic [CHAR_W-1:0] tx_char_out,
  input wire logic tx_char_valid_out,
  input wire logic tx_char_ready_in,
  input wire logic tx_halted_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_take;
    tx_data_valid_in && tx_data_ready_out;
  endsequence
  sequence s_status_read;
    reg_rd_in && reg_addr_in == inband_flow_pkg::ADDR_STATUS;
  endsequence

  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data present without a read");
  a_status_halt: assert property (s_status_read |=>
    reg_rdata_out[inband_flow_pkg::STAT_HALTED_BIT] == $past(tx_halted_out))
    else $error("status halted bit differs from halted output");
  a_rx_forward: assert property (rx_fifo_wr_out |->
    $past(rx_char_valid_in) && rx_fifo_data_out == $past(rx_char_in))
    else $error("receive write without a matching received character");
  a_tx_hold: assert property (tx_char_valid_out && !tx_char_ready_in |=>
    tx_char_valid_out && $stable(tx_char_out))
    else $error("character to transmitter dropped or changed before taken");
  a_take_load: assert property (s_take |=>
    tx_char_valid_out && tx_char_out == $past(tx_data_in) && !tx_data_ready_out)
    else $error("taken data not presented to transmitter");
  a_halt_block: assert property (tx_halted_out && $past(tx_halted_out) |->
    !tx_data_ready_out)
    else $error("data accepted while halted");
  a_slot_busy: assert property (tx_char_valid_out |-> !tx_data_ready_out)
    else $error("data accepted while the transmit slot is full");
  a_reset_clear: assert property ($past(sys_rst_in) |-> !tx_char_valid_out &&
    !rx_fifo_wr_out && !tx_halted_out && !tx_data_ready_out && reg_rdata_out == 8'h00)
    else $error("outputs not cleared after reset");
endmodule
